// >>> core/phy_management_port.sv
`timescale 1ns/1ps
`default_nettype none
module phy_management_port
	import phy_mgmt_pkg::*;
#(
	parameter int LANES = 1,
	parameter bit RX_ONLY = 1'b0,
	parameter int RIN_W = (RX_ONLY ? RCFG_IN_RXONLY : RCFG_IN_DUPLEX) * LANES,
	parameter int ROUT_W = (RX_ONLY ? RCFG_OUT_RXONLY : RCFG_OUT_DUPLEX) * LANES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Management target port from the host
	input wire logic [ADDR_W-1:0] csr_addr_i,
	input wire logic [DATA_W-1:0] csr_wdata_i,
	input wire logic csr_write_i,
	input wire logic csr_read_i,
	output logic [DATA_W-1:0] csr_rdata_o,
	output logic csr_stall_o,
	// Initiator port toward the lane logic
	output logic [ADDR_W-1:0] lane_addr_o,
	output logic [DATA_W-1:0] lane_wdata_o,
	output logic lane_write_o,
	output logic lane_read_o,
	input wire logic [DATA_W-1:0] lane_rdata_i,
	input wire logic lane_stall_i,
	// Reconfiguration buses
	input wire logic [RIN_W-1:0] reconfiguration_in_bus_i,
	output logic [ROUT_W-1:0] reconfiguration_out_bus_o,
	input wire logic reconfig_busy_i,
	output logic reconfig_busy_o,
	// Serial lanes and reset to the lane logic
	input wire logic [LANES-1:0] rx_serial_i,
	output logic [LANES-1:0] tx_serial_o,
	input wire logic [LANES-1:0] lane_tx_serial_i,
	output logic [LANES-1:0] lane_rx_serial_o,
	input wire logic [ROUT_W-1:0] lane_reconfig_out_i,
	output logic [RIN_W-1:0] lane_reconfig_in_o,
	output logic core_reset_o
);

	// ========================================
	// Reset
	// The management reset is active high at the device edge; rstn_i is its
	// inverse here, and the core reset output holds every other part in reset.
	logic nxt_core_reset;
	logic core_reset_ff;

	always_comb begin
		nxt_core_reset = 1'b0;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			core_reset_ff <= 1'b1;
		end else begin
			core_reset_ff <= nxt_core_reset;
		end
	end

	// ========================================
	// Bridge
	// A single flat map is passed straight through; the address is not
	// decoded here so that every lane register stays reachable.
	bridge_state_t state_ff;
	bridge_state_t nxt_state;
	logic [ADDR_W-1:0] addr_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] nxt_wdata;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic wr_ff;
	logic nxt_wr;
	logic rd_ff;
	logic nxt_rd;
	logic stall_ff;
	logic nxt_stall;

	always_comb begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_wr = wr_ff;
		nxt_rd = rd_ff;
		nxt_stall = stall_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_stall = 1'b1;
				if (csr_write_i || csr_read_i) begin
					nxt_addr = csr_addr_i;
					nxt_wdata = csr_wdata_i;
					// Read wins when both strobes are high, so no write is half done.
					nxt_wr = csr_write_i && !csr_read_i;
					nxt_rd = csr_read_i;
					nxt_state = ST_FWD;
				end
			end
			ST_FWD: begin
				if (!lane_stall_i) begin
					nxt_wr = 1'b0;
					nxt_rd = 1'b0;
					if (rd_ff) begin
						nxt_rdata = lane_rdata_i;
					end
					nxt_stall = 1'b0;
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				// Stall is low for this one cycle; the host finishes here.
				nxt_stall = 1'b1;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_wr = 1'b0;
				nxt_rd = 1'b0;
				nxt_stall = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff <= ST_IDLE;
			addr_ff <= ADDR_RST;
			wdata_ff <= RDATA_RST;
			rdata_ff <= RDATA_RST;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			stall_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			stall_ff <= nxt_stall;
		end
	end

	// ========================================
	// Reconfiguration input bus
	// Reconfiguration words share the management clock and pass one register.
	logic [RIN_W-1:0] rcfg_in_ff;
	logic [RIN_W-1:0] nxt_rcfg_in;

	always_comb begin
		nxt_rcfg_in = reconfiguration_in_bus_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rcfg_in_ff <= '0;
		end else begin
			rcfg_in_ff <= nxt_rcfg_in;
		end
	end

	// ========================================
	// Reconfiguration output bus
	logic [ROUT_W-1:0] rcfg_out_ff;
	logic [ROUT_W-1:0] nxt_rcfg_out;

	always_comb begin
		nxt_rcfg_out = lane_reconfig_out_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rcfg_out_ff <= '0;
		end else begin
			rcfg_out_ff <= nxt_rcfg_out;
		end
	end

	// ========================================
	// Reconfiguration busy monitor
	// The busy line runs on the management clock, so one register suffices.
	logic busy_ff;
	logic nxt_busy;

	always_comb begin
		nxt_busy = reconfig_busy_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end

	// ========================================
	// Settling filter
	// A serial bit counts only once the second and third stages agree, so a
	// one-cycle glitch never reaches the lane copies.
	function automatic logic [LANES-1:0] settle(
		input logic [LANES-1:0] mid,
		input logic [LANES-1:0] last,
		input logic [LANES-1:0] held
	);
		settle = (mid & last) | (held & (mid | last));
	endfunction : settle

	// ========================================
	// Receive pin synchroniser
	// Serial wires carry no management timing, so they are resampled here;
	// the price is four cycles of latency on the registered copies.
	logic [LANES-1:0] rx_meta_ff;
	logic [LANES-1:0] nxt_rx_meta;
	logic [LANES-1:0] rx_mid_ff;
	logic [LANES-1:0] nxt_rx_mid;
	logic [LANES-1:0] rx_last_ff;
	logic [LANES-1:0] nxt_rx_last;

	always_comb begin
		nxt_rx_meta = rx_serial_i;
		nxt_rx_mid = rx_meta_ff;
		nxt_rx_last = rx_mid_ff;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_meta_ff <= '0;
			rx_mid_ff <= '0;
			rx_last_ff <= '0;
		end else begin
			rx_meta_ff <= nxt_rx_meta;
			rx_mid_ff <= nxt_rx_mid;
			rx_last_ff <= nxt_rx_last;
		end
	end

	// ========================================
	// Transmit pin synchroniser
	// The transmit copy is filtered the same way, so both keep one latency.
	logic [LANES-1:0] tx_meta_ff;
	logic [LANES-1:0] nxt_tx_meta;
	logic [LANES-1:0] tx_mid_ff;
	logic [LANES-1:0] nxt_tx_mid;
	logic [LANES-1:0] tx_last_ff;
	logic [LANES-1:0] nxt_tx_last;

	always_comb begin
		nxt_tx_meta = lane_tx_serial_i;
		nxt_tx_mid = tx_meta_ff;
		nxt_tx_last = tx_mid_ff;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_meta_ff <= '0;
			tx_mid_ff <= '0;
			tx_last_ff <= '0;
		end else begin
			tx_meta_ff <= nxt_tx_meta;
			tx_mid_ff <= nxt_tx_mid;
			tx_last_ff <= nxt_tx_last;
		end
	end

	// ========================================
	// Serial lane registers
	logic [LANES-1:0] tx_ff;
	logic [LANES-1:0] nxt_tx;
	logic [LANES-1:0] rx_ff;
	logic [LANES-1:0] nxt_rx;

	always_comb begin
		nxt_tx = settle(tx_mid_ff, tx_last_ff, tx_ff);
		nxt_rx = settle(rx_mid_ff, rx_last_ff, rx_ff);
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_ff <= '0;
			rx_ff <= '0;
		end else begin
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
		end
	end

	// ========================================
	// Outputs
	assign csr_rdata_o = rdata_ff;
	assign csr_stall_o = stall_ff;
	assign lane_addr_o = addr_ff;
	assign lane_wdata_o = wdata_ff;
	assign lane_write_o = wr_ff;
	assign lane_read_o = rd_ff;
	assign reconfiguration_out_bus_o = rcfg_out_ff;
	assign lane_reconfig_in_o = rcfg_in_ff;
	assign reconfig_busy_o = busy_ff;
	assign tx_serial_o = tx_ff;
	assign lane_rx_serial_o = rx_ff;
	assign core_reset_o = core_reset_ff;

endmodule : phy_management_port
`default_nettype wire

// >>> core/phy_mgmt_pkg.sv
// Notes on behaviour
// - Management clock times the CSR port, reconfiguration buses and reset sequencer.
// - Management reset is active high, level sensitive, holds everything in reset.
// - Host presents a 9-bit register address sampled on the management clock.
// - Word addresses; 32-bit write data in, 32-bit read data out.
// - Stall is high while a pending request cannot yet complete.
// - Reconfiguration input bus is 140 bits per lane, 70 for receive-only.
// - Reconfiguration output bus is 92 bits per lane, 46 for receive-only.
// - One serial transmit output and one serial receive input per lane.
// - Every accepted command is forwarded out the initiator port to the lane logic.
// - The port exposes coding, analogue, reset, error and loopback control.
// - All registers share one flat address space, with no banking.
`default_nettype none
package phy_mgmt_pkg;

	// ========================================
	// Widths
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int RCFG_IN_DUPLEX = 140;
	localparam int RCFG_IN_RXONLY = 70;
	localparam int RCFG_OUT_DUPLEX = 92;
	localparam int RCFG_OUT_RXONLY = 46;

	// ========================================
	// Reset values
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;

	// ========================================
	// Bridge states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FWD = 3'b010,
		ST_DONE = 3'b100
	} bridge_state_t;

endpackage : phy_mgmt_pkg
`default_nettype wire

// >>> tb/lane_responder.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Lane responder; holds off for wait_i cycles.
module lane_responder
	import phy_mgmt_pkg::*;
(
	input wire logic mclk_i,
	input wire logic req_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wait_i,
	output logic stall_o,
	output logic [DATA_W-1:0] rdata_o
);
	logic [7:0] cnt_ff = 8'h00;
	assign stall_o = req_i && cnt_ff < wait_i;
	// Data outside the answer is the inverted wait count, so a late sample fails.
	assign rdata_o = (req_i && !stall_o) ? {23'h001234, addr_i} : {4{~cnt_ff}};
	always_ff @(posedge mclk_i) cnt_ff <= stall_o ? cnt_ff + 8'h01 : 8'h00;
endmodule : lane_responder
`default_nettype wire

// >>> tb/mgmt_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Bridge checker.
module mgmt_chk
	import phy_mgmt_pkg::*;
#(parameter int RIN_W = 140, parameter int ROUT_W = 92) (
	// Host side
	input wire logic mclk_i, rstn_i, csr_stall_o, core_reset_o,
	input wire logic [ADDR_W-1:0] csr_addr_i, lane_addr_o,
	input wire logic [DATA_W-1:0] csr_wdata_i, csr_rdata_o,
	// Lane side
	input wire logic lane_write_o, lane_read_o, lane_stall_i,
	input wire logic [DATA_W-1:0] lane_wdata_o, lane_rdata_i,
	input wire logic [RIN_W-1:0] reconfiguration_in_bus_i, lane_reconfig_in_o,
	input wire logic [ROUT_W-1:0] lane_reconfig_out_i, reconfiguration_out_bus_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	wire req = lane_write_o | lane_read_o;
	sequence s_end; req && !lane_stall_i; endsequence
	property p_fwd; $rose(lane_write_o) |-> lane_addr_o == $past(csr_addr_i)
		&& lane_wdata_o == $past(csr_wdata_i); endproperty
	a_fwd: assert property (p_fwd) else $error("bad forward");
	property p_hold; req && lane_stall_i |=> req && $stable(lane_addr_o);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_wait; req && lane_stall_i |=> csr_stall_o; endproperty
	a_wait: assert property (p_wait) else $error("stall early");
	property p_done; s_end |=> !csr_stall_o ##1 csr_stall_o; endproperty
	a_done: assert property (p_done) else $error("bad end");
	property p_rd; s_end ##0 lane_read_o |=> csr_rdata_o == $past(lane_rdata_i);
	endproperty
	a_rd: assert property (p_rd) else $error("bad read data");
	property p_rst; core_reset_o == !$past(rstn_i); endproperty
	a_rst: assert property (p_rst) else $error("bad core reset");
	property p_cin; $past(rstn_i) |->
		lane_reconfig_in_o == $past(reconfiguration_in_bus_i); endproperty
	a_cin: assert property (p_cin) else $error("bad bus in");
	property p_cout; $past(rstn_i) |->
		reconfiguration_out_bus_o == $past(lane_reconfig_out_i); endproperty
	a_cout: assert property (p_cout) else $error("bad bus out");
endmodule : mgmt_chk
bind phy_management_port mgmt_chk #(.RIN_W(RIN_W), .ROUT_W(ROUT_W)) u_chk (.*);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Bench.
module testbench
	import phy_mgmt_pkg::*;
;
	logic mclk_i = 1'b0, rstn_i = 1'b0, csr_write_i = 1'b0, csr_read_i = 1'b0;
	logic [ADDR_W-1:0] csr_addr_i = '0, lane_addr_o;
	logic [DATA_W-1:0] csr_wdata_i = '0, csr_rdata_o, lane_wdata_o, lane_rdata_i;
	logic csr_stall_o, lane_write_o, lane_read_o, lane_stall_i, core_reset_o;
	logic reconfig_busy_i = 1'b0, reconfig_busy_o;
	logic [0:0] rx_serial_i = '0, tx_serial_o, lane_tx_serial_i = '0;
	logic [0:0] lane_rx_serial_o;
	logic [139:0] reconfiguration_in_bus_i = '0, lane_reconfig_in_o;
	logic [91:0] lane_reconfig_out_i = '0, reconfiguration_out_bus_o;
	logic [7:0] wt = 8'h00;
	int mismatches = 0, n_checks = 0;
	phy_management_port dut (.*);
	lane_responder u_lane (.mclk_i, .req_i(lane_write_o | lane_read_o),
		.addr_i(lane_addr_o), .wait_i(wt), .stall_o(lane_stall_i),
		.rdata_o(lane_rdata_i));
	initial forever #20 mclk_i = ~mclk_i;
	task automatic chk(input logic [143:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task tick;
		@(posedge mclk_i);
		#1;
	endtask : tick
	// One transfer; the stall count must be the lane wait plus three.
	task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] n);
		int c;
		wt = n;
		csr_addr_i = a;
		csr_wdata_i = {a, 23'h7fffff};
		csr_write_i = w;
		csr_read_i = !w;
		for (c = 1; c < 300 && csr_stall_o !== 1'b0; c++) tick;
		chk(c, n + 3);
		tick;
		csr_write_i = 1'b0;
		csr_read_i = 1'b0;
		if (!w) chk(csr_rdata_o, {23'h001234, a});
		chk(csr_stall_o, 1'b1);
		tick;
	endtask : xfer
	task t_bus;
		xfer(1'b1, 9'h1ff, 8'h00);
		xfer(1'b0, 9'h000, 8'h00);
		xfer(1'b0, 9'h1ff, 8'h05);
		xfer(1'b1, 9'h0aa, 8'h02);
	endtask : t_bus
	task t_pass;
		reconfiguration_in_bus_i = {35{4'ha}};
		lane_reconfig_out_i = {23{4'h6}};
		rx_serial_i = 1'b1;
		lane_tx_serial_i = 1'b1;
		tick;
		reconfig_busy_i = 1'b1;
		chk(lane_reconfig_in_o, {35{4'ha}});
		chk(reconfiguration_out_bus_o, {23{4'h6}});
		chk({tx_serial_o, lane_rx_serial_o}, 2'h0);
		repeat (3) tick;
		chk({reconfig_busy_o, tx_serial_o, lane_rx_serial_o}, 3'h7);
		rx_serial_i = 1'b0;
		tick;
		rx_serial_i = 1'b1;
		repeat (4) begin
			tick;
			chk(lane_rx_serial_o, 1'b1);
		end
	endtask : t_pass
	task t_rst;
		rstn_i = 1'b0;
		#1;
		chk({core_reset_o, csr_stall_o, lane_reconfig_in_o}, 142'h3 << 140);
		tick;
		rstn_i = 1'b1;
		tick;
		chk(core_reset_o, 1'b0);
	endtask : t_rst
	initial begin
		#20000;
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		rstn_i = 1'b1;
		tick;
		t_bus;
		t_pass;
		t_rst;
		t_bus;
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
